// File: logic/ltbf_defines.vh
// shared constants for the transmit burst framer
// assumes inclusion by bare name from the framer, monitor and bench sources
`ifndef LTBF_DEFINES_VH
`define LTBF_DEFINES_VH

// ****************************************************
// register offsets (byte addresses, one word each)
// ****************************************************
`define LTBF_ADDR_CFG 8'h00
`define LTBF_ADDR_STATUS 8'h04

// ****************************************************
// config register fields
// ****************************************************
`define LTBF_CFG_MAX_LSB 0
`define LTBF_CFG_MAX_W 8
`define LTBF_CFG_SHORT_LSB 8
`define LTBF_CFG_SHORT_W 4
`define LTBF_CFG_THR_LSB 16
`define LTBF_CFG_THR_W 6

// reset values: burst sizes in 64-bit words, ready slack in queue words
`define LTBF_RST_MAX 8'h20
`define LTBF_RST_SHORT 4'h4
`define LTBF_RST_THR 6'h04

// ****************************************************
// status register fields
// ****************************************************
`define LTBF_ST_OVF 0
`define LTBF_ST_RDY 1
`define LTBF_ST_OPEN 2
`define LTBF_ST_LVL_LSB 8

// ****************************************************
// control word layout
// ****************************************************
`define LTBF_CW_BURST 63
`define LTBF_CW_SOP 62
`define LTBF_CW_EOP_MSB 61
`define LTBF_CW_EOP_LSB 58
`define LTBF_CW_ERR 57
`define LTBF_CW_CHAN_LSB 40

// data word size in bytes
`define LTBF_WORD_BYTES 8

`endif

// File: logic/ltbf_tx_framer.v
// transmit packet bus front end: cuts packets into framed bursts
// assumes one core clock, packet source logic on that same clock,
// and a downstream lane stage that takes one 64-bit word per cycle
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "ltbf_defines.vh"

// Behaviour
// - all bus signals sampled on rising clock
// - first byte in top byte lane
// - empty count used only with end mark
// - empty count N voids N low byte lanes
// - error flag marks the closing control word
// - error forces low empty bits to zero
// - overflow flagged on a write into a full queue
// - transmit reset needed after any overflow
// - bursts framed by burst control words
// - packet bursts exactly max size except last or cut by force or channel
// - idle words pad bursts below minimum
// - interleaved boundaries from force, sizes, channel
// - force-burst injects a burst control word
module ltbf_tx_framer #(
  parameter BUS_W = 128,
  parameter MTY_W = 4,
  parameter CH_W = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // packet write bus
  input wire tx_wr_valid,
  input wire tx_pkt_start,
  input wire tx_pkt_end,
  input wire tx_err,
  input wire tx_force_burst,
  input wire [CH_W-1:0] tx_chan,
  input wire [BUS_W-1:0] tx_data,
  input wire [MTY_W-1:0] tx_empty_cnt,
  // back-pressure
  output wire tx_ready,
  output wire tx_overflow,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  // framed word stream
  output wire out_valid,
  output wire out_ctl,
  output wire [63:0] out_word
);

  // ****************************************************
  // derived sizes
  // ****************************************************
  localparam LANES = BUS_W / 64; // data words per bus word
  localparam BYTES = BUS_W / 8; // bytes per bus word
  localparam EW = BUS_W + MTY_W + CH_W + 4; // queue entry width

  // ****************************************************
  // functions
  // ****************************************************
  // valid bytes of an end word, error clears low empty bits
  function [7:0] valid_bytes;
    input [MTY_W-1:0] mty;
    input err;
    reg [7:0] m;
    begin
      m = {{(8-MTY_W){1'b0}}, mty};
      if (err) begin
        m[2:0] = 3'h0;
      end
      valid_bytes = BYTES[7:0] - m;
    end
  endfunction

  // count of data words that carry valid bytes
  function [7:0] used_words;
    input [7:0] vb;
    begin
      used_words = (vb + 8'h07) >> 3;
    end
  endfunction

  // control word builder
  function [63:0] ctl_word;
    input burst;
    input sop;
    input [3:0] ecode;
    input err;
    input [CH_W-1:0] chan;
    reg [63:0] w;
    begin
      w = 64'h0;
      w[`LTBF_CW_BURST] = burst;
      w[`LTBF_CW_SOP] = sop;
      w[`LTBF_CW_EOP_MSB:`LTBF_CW_EOP_LSB] = ecode;
      w[`LTBF_CW_ERR] = err;
      w[`LTBF_CW_CHAN_LSB +: CH_W] = chan;
      ctl_word = w;
    end
  endfunction

  // ****************************************************
  // registers and queue wiring
  // ****************************************************
  reg [7:0] cfg_max_reg; // burst max in words
  reg [3:0] cfg_short_reg; // burst short in words
  reg [5:0] cfg_thr_reg; // ready slack
  reg [31:0] rdata_reg; // read data
  reg ready_reg; // accept ready
  reg ovf_reg; // sticky overflow
  reg open_reg, open_next; // a burst is open
  wire q_full; // queue full
  wire q_empty; // queue empty
  wire [AW:0] q_level; // queue level
  wire [EW-1:0] q_out; // head entry
  wire q_pop; // take head entry
  wire [EW-1:0] q_in; // entry packed from the bus

  // entry: data, empty, channel, start, end, error, force
  assign q_in = {tx_data, tx_empty_cnt, tx_chan, tx_pkt_start,
                 tx_pkt_end, tx_err, tx_force_burst};

  // queue of whole bus words
  ltbf_word_fifo #(
    .WIDTH(EW),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_queue (
    .core_clk(core_clk),
    .reset(reset),
    .wr_en(tx_wr_valid),
    .wr_data(q_in),
    .full(q_full),
    .rd_en(q_pop),
    .rd_data(q_out),
    .empty(q_empty),
    .level(q_level)
  );

  // head entry fields
  wire [BUS_W-1:0] h_data = q_out[EW-1 -: BUS_W];
  wire [MTY_W-1:0] h_mty = q_out[CH_W+4 +: MTY_W];
  wire [CH_W-1:0] h_chan = q_out[4 +: CH_W];
  wire h_sop = q_out[3];
  wire h_eop = q_out[2];
  wire h_err = q_out[1];
  wire h_bctl = q_out[0];
  wire [7:0] h_vb = valid_bytes(h_mty, h_err);
  wire [7:0] h_nw = used_words(h_vb);

  // ****************************************************
  // register port and back-pressure
  // ****************************************************
  // config writes, status reads, one-cycle read latency
  always @(posedge core_clk) begin
    if (reset) begin
      cfg_max_reg <= `LTBF_RST_MAX;
      cfg_short_reg <= `LTBF_RST_SHORT;
      cfg_thr_reg <= `LTBF_RST_THR;
      rdata_reg <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == `LTBF_ADDR_CFG) begin
        cfg_max_reg <= reg_wdata[`LTBF_CFG_MAX_LSB +: `LTBF_CFG_MAX_W];
        cfg_short_reg <= reg_wdata[`LTBF_CFG_SHORT_LSB +:
                                   `LTBF_CFG_SHORT_W];
        cfg_thr_reg <= reg_wdata[`LTBF_CFG_THR_LSB +: `LTBF_CFG_THR_W];
      end
      rdata_reg <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          `LTBF_ADDR_CFG: begin
            rdata_reg[`LTBF_CFG_MAX_LSB +: `LTBF_CFG_MAX_W] <= cfg_max_reg;
            rdata_reg[`LTBF_CFG_SHORT_LSB +: `LTBF_CFG_SHORT_W] <=
              cfg_short_reg;
            rdata_reg[`LTBF_CFG_THR_LSB +: `LTBF_CFG_THR_W] <= cfg_thr_reg;
          end
          `LTBF_ADDR_STATUS: begin
            rdata_reg[`LTBF_ST_OVF] <= ovf_reg;
            rdata_reg[`LTBF_ST_RDY] <= ready_reg;
            rdata_reg[`LTBF_ST_OPEN] <= open_reg;
            rdata_reg[`LTBF_ST_LVL_LSB +: AW+1] <= q_level;
          end
          default: begin
            rdata_reg <= 32'h0; // unmapped reads zero
          end
        endcase
      end
    end
  end

  // words held once this cycle's write lands, plus the slack
  wire [15:0] slack_need = {{(15-AW){1'b0}}, q_level} +
                           {10'h000, cfg_thr_reg} +
                           {15'h0000, tx_wr_valid};

  // ready while slack room remains, overflow sticky to reset
  always @(posedge core_clk) begin
    if (reset) begin
      ready_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      ready_reg <= (slack_need < DEPTH[15:0]);
      // write into a full queue; no clear path other than reset
      ovf_reg <= ovf_reg | (tx_wr_valid & q_full);
    end
  end

  // ****************************************************
  // framer state
  // ****************************************************
  reg closing_reg, closing_next; // burst takes no more data
  reg [7:0] len_reg, len_next; // words in current burst
  reg [CH_W-1:0] cur_chan_reg, cur_chan_next; // burst channel
  reg pend_reg, pend_next; // end info waits for a control word
  reg [3:0] pend_code_reg, pend_code_next; // pending end code
  reg pend_err_reg, pend_err_next; // pending error mark
  reg [BUS_W-1:0] sh_reg, sh_next; // lane shifter
  reg [7:0] lane_reg, lane_next; // lanes emitted from head
  reg ctl_done_reg, ctl_done_next; // head already got its control word
  reg ov_reg, ov_next; // out valid
  reg oc_reg, oc_next; // out control marker
  reg [63:0] ow_reg, ow_next; // out word
  reg pop_c; // head word finished
  reg need_new; // head word needs a new burst
  reg [7:0] last_lane; // last lane carrying data
  reg [7:0] last_bytes; // bytes in last data word

  assign q_pop = pop_c;

  // decide one output word per cycle
  always @* begin
    open_next = open_reg;
    closing_next = closing_reg;
    len_next = len_reg;
    cur_chan_next = cur_chan_reg;
    pend_next = pend_reg;
    pend_code_next = pend_code_reg;
    pend_err_next = pend_err_reg;
    sh_next = sh_reg;
    lane_next = lane_reg;
    ctl_done_next = ctl_done_reg;
    ov_next = 1'b0;
    oc_next = 1'b0;
    ow_next = 64'h0;
    pop_c = 1'b0;
    // empty count only matters on an end word
    last_lane = h_eop ? h_nw - 8'h01 : LANES[7:0] - 8'h01;
    last_bytes = h_vb - ((h_nw - 8'h01) << 3);
    // new burst on start, force, channel change or full burst
    need_new = !q_empty &&
               ((!ctl_done_reg &&
                 (h_sop || h_bctl || h_chan != cur_chan_reg)) ||
                len_reg >= cfg_max_reg);
    if ((closing_reg || (open_reg && need_new)) &&
        len_reg < {4'h0, cfg_short_reg}) begin
      // pad short burst with idles, first carries end info
      ov_next = 1'b1;
      oc_next = 1'b1;
      ow_next = ctl_word(1'b0, 1'b0, pend_code_reg, pend_err_reg,
                         {CH_W{1'b0}});
      pend_next = 1'b0;
      pend_code_next = 4'h0;
      pend_err_next = 1'b0;
      closing_next = 1'b1;
      len_next = len_reg + 8'h01;
    end else if (!q_empty && (!open_reg || closing_reg || need_new)) begin
      // burst control word also closes the previous burst
      ov_next = 1'b1;
      oc_next = 1'b1;
      ow_next = ctl_word(1'b1, h_sop && lane_reg == 8'h00,
                         pend_code_reg, pend_err_reg, h_chan);
      pend_next = 1'b0;
      pend_code_next = 4'h0;
      pend_err_next = 1'b0;
      open_next = 1'b1;
      closing_next = 1'b0;
      len_next = 8'h00;
      cur_chan_next = h_chan;
      ctl_done_next = 1'b1;
      if (lane_reg == 8'h00) begin
        sh_next = h_data;
      end
    end else if (!q_empty) begin
      // data lane, top bytes first
      ov_next = 1'b1;
      ow_next = (lane_reg == 8'h00) ? h_data[BUS_W-1 -: 64] :
                sh_reg[BUS_W-1 -: 64];
      sh_next = ((lane_reg == 8'h00) ? h_data : sh_reg) << 64;
      len_next = len_reg + 8'h01;
      lane_next = lane_reg + 8'h01;
      if (lane_reg == last_lane) begin
        pop_c = 1'b1;
        lane_next = 8'h00;
        ctl_done_next = 1'b0;
        if (h_eop) begin
          // end of packet: next control word carries the end
          closing_next = 1'b1;
          pend_next = 1'b1;
          pend_code_next = {1'b1, last_bytes[2:0] - 3'h1};
          pend_err_next = h_err;
        end
      end
    end else if (closing_reg) begin
      // nothing follows: close with an idle if info is pending
      ov_next = pend_reg;
      oc_next = pend_reg;
      ow_next = pend_reg ? ctl_word(1'b0, 1'b0, pend_code_reg,
                                    pend_err_reg, {CH_W{1'b0}}) : 64'h0;
      pend_next = 1'b0;
      pend_code_next = 4'h0;
      pend_err_next = 1'b0;
      open_next = 1'b0;
      closing_next = 1'b0;
      len_next = 8'h00;
    end
  end

  // framer state flops
  always @(posedge core_clk) begin
    if (reset) begin
      open_reg <= 1'b0;
      closing_reg <= 1'b0;
      len_reg <= 8'h00;
      cur_chan_reg <= {CH_W{1'b0}};
      pend_reg <= 1'b0;
      pend_code_reg <= 4'h0;
      pend_err_reg <= 1'b0;
      sh_reg <= {BUS_W{1'b0}};
      lane_reg <= 8'h00;
      ctl_done_reg <= 1'b0;
      ov_reg <= 1'b0;
      oc_reg <= 1'b0;
      ow_reg <= 64'h0;
    end else begin
      open_reg <= open_next;
      closing_reg <= closing_next;
      len_reg <= len_next;
      cur_chan_reg <= cur_chan_next;
      pend_reg <= pend_next;
      pend_code_reg <= pend_code_next;
      pend_err_reg <= pend_err_next;
      sh_reg <= sh_next;
      lane_reg <= lane_next;
      ctl_done_reg <= ctl_done_next;
      ov_reg <= ov_next;
      oc_reg <= oc_next;
      ow_reg <= ow_next;
    end
  end

  // ****************************************************
  // outputs, all from flops
  // ****************************************************
  assign tx_ready = ready_reg;
  assign tx_overflow = ovf_reg;
  assign reg_rdata = rdata_reg;
  assign out_valid = ov_reg;
  assign out_ctl = oc_reg;
  assign out_word = ow_reg;

endmodule

// File: logic/ltbf_word_fifo.v
// show-ahead word queue between the packet bus and the framer
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps

module ltbf_word_fifo #(
  parameter WIDTH = 144,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // fill side
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  output wire full,
  // drain side
  input wire rd_en,
  output wire [WIDTH-1:0] rd_data,
  output wire empty,
  // fill level
  output wire [AW:0] level
);

  // ****************************************************
  // storage and pointers
  // ****************************************************
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // word array
  reg [AW-1:0] wr_ptr_reg; // next write slot
  reg [AW-1:0] rd_ptr_reg; // next read slot
  reg [AW:0] cnt_reg; // words held
  wire do_wr; // accepted write
  wire do_rd; // accepted read

  assign full = (cnt_reg == DEPTH[AW:0]);
  assign empty = (cnt_reg == {(AW+1){1'b0}});
  assign level = cnt_reg;
  assign rd_data = mem[rd_ptr_reg];
  // a write into a full queue is dropped
  assign do_wr = wr_en && !full;
  assign do_rd = rd_en && !empty;

  // array write, no reset needed
  always @(posedge core_clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= wr_data;
    end
  end

  // pointer and count update
  always @(posedge core_clk) begin
    if (reset) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
                      {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
                      {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      // both at once leave the count unchanged
      if (do_wr && !do_rd) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule

// File: tb/ltbf_pkt_src.sv
// packet source model on the framer's write bus
// assumes a 128-bit bus; byte k of a packet is tag plus k
`timescale 1ns/1ps

module ltbf_pkt_src (
  // clock
  input wire logic core_clk,
  // back-pressure
  input wire logic tx_ready,
  // packet write bus
  output logic tx_wr_valid,
  output logic tx_pkt_start,
  output logic tx_pkt_end,
  output logic tx_err,
  output logic tx_force_burst,
  output logic [7:0] tx_chan,
  output logic [127:0] tx_data,
  output logic [3:0] tx_empty_cnt
);
  // idle bus at time zero
  initial begin
    tx_wr_valid = 1'b0;
    tx_pkt_start = 1'b0;
    tx_pkt_end = 1'b0;
    tx_err = 1'b0;
    tx_force_burst = 1'b0;
    tx_chan = 8'h00;
    tx_data = 128'h0;
    tx_empty_cnt = 4'h0;
  end

  // one packet of nw words; ign skips the ready wait
  task automatic send(input logic [7:0] ch, input logic [7:0] tag,
      input integer nw, input logic [3:0] mty, input logic er,
      input integer fw, input logic ign);
    integer w;
    integer i;
    logic [127:0] dw;
    begin
      for (w = 0; w < nw; w = w + 1) begin
        @(negedge core_clk);
        // a stalled source drops valid instead of repeating a word
        while (!ign && tx_ready !== 1'b1) begin
          @(posedge core_clk);
          tx_wr_valid <= 1'b0;
          @(negedge core_clk);
        end
        for (i = 0; i < 16; i = i + 1) begin
          dw[127-8*i -: 8] = tag + 8'(w*16+i);
        end
        @(posedge core_clk);
        tx_wr_valid <= 1'b1;
        tx_pkt_start <= (w == 0);
        tx_pkt_end <= (w == nw - 1);
        tx_err <= er && (w == nw - 1);
        tx_force_burst <= (w == fw);
        tx_chan <= ch;
        tx_empty_cnt <= (w == nw - 1) ? mty : 4'h0;
        tx_data <= dw;
      end
      @(posedge core_clk);
      tx_wr_valid <= 1'b0;
      tx_pkt_start <= 1'b0;
      tx_pkt_end <= 1'b0;
      tx_force_burst <= 1'b0;
      tx_data <= ~tx_data; // released data and channel lines do not keep their value
      tx_chan <= ~tx_chan;
    end
  endtask
endmodule

// File: tb/ltbf_tx_monitor.sv
// port assertions for the transmit burst framer
// assumes a bind onto ltbf_tx_framer, one clock, sync reset
`timescale 1ns/1ps
`include "ltbf_defines.vh"

module ltbf_tx_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // packet bus
  input wire logic tx_wr_valid,
  input wire logic tx_ready,
  input wire logic tx_overflow,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // framed stream
  input wire logic out_valid,
  input wire logic out_ctl,
  input wire logic [63:0] out_word
);
  // ****************
  // helper state
  // ****************
  logic late_wr_reg; // write made while not ready
  logic in_burst_reg; // burst opened, not yet closed by an idle
  // track late writes and the open burst
  always @(posedge core_clk) begin
    late_wr_reg <= tx_wr_valid && !tx_ready;
    if (reset) begin
      in_burst_reg <= 1'b0;
    end else if (out_valid && out_ctl) begin
      in_burst_reg <= out_word[63];
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // ****************
  // sequences and assertions
  // ****************
  sequence sop_ctl_s;
    out_valid && out_ctl && out_word[62];
  endsequence
  sequence data_s;
    out_valid && !out_ctl;
  endsequence

  ovf_hold_a: assert property (tx_overflow |=> tx_overflow)
    else $error("overflow dropped without reset");
  ovf_cause_a: assert property (
    $rose(tx_overflow) |-> late_wr_reg || $past(late_wr_reg))
    else $error("overflow without a late write");
  reset_clear_a: assert property (disable iff (1'b0)
    reset |=> !tx_overflow && !out_valid && !tx_ready)
    else $error("outputs not cleared by reset");
  rdata_zero_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read answer");
  status_bits_a: assert property (
    reg_rd && reg_addr == `LTBF_ADDR_STATUS |=>
    reg_rdata[1:0] == {$past(tx_ready), $past(tx_overflow)})
    else $error("status bits wrong");
  data_burst_a: assert property (data_s |-> in_burst_reg)
    else $error("data word outside a burst");
  sop_burst_a: assert property (
    sop_ctl_s |-> out_word[63] && out_word[39:0] == 40'h0 ##1 data_s)
    else $error("start burst word malformed");
  err_end_a: assert property (
    out_valid && out_ctl && out_word[57] |-> out_word[61])
    else $error("error flag without end code");
endmodule

bind ltbf_tx_framer ltbf_tx_monitor u_ltbf_tx_monitor (
  .core_clk(core_clk), .reset(reset), .tx_wr_valid(tx_wr_valid),
  .tx_ready(tx_ready), .tx_overflow(tx_overflow), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_valid(out_valid),
  .out_ctl(out_ctl), .out_word(out_word)
);

// File: tb/testbench.sv
// self-checking bench for the transmit burst framer
// assumes a 50 ns core clock and the packet source model
`timescale 1ns/1ps
`include "ltbf_defines.vh"

module testbench;
  logic core_clk;
  logic reset;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] r;
  wire [31:0] reg_rdata;
  wire tx_wr_valid, tx_pkt_start, tx_pkt_end, tx_err, tx_force_burst;
  wire [7:0] tx_chan;
  wire [127:0] tx_data;
  wire [3:0] tx_empty_cnt;
  wire tx_ready, tx_overflow, out_valid, out_ctl;
  wire [63:0] out_word;
  integer seed, miscompares, cmp_count, i;
  logic [64:0] got[$]; // seen words, control flag on top
  logic [64:0] exp[$]; // expected words

  ltbf_tx_framer #(.DEPTH(8), .AW(3)) u_ltbf_tx_framer (
    .core_clk(core_clk), .reset(reset), .tx_wr_valid(tx_wr_valid),
    .tx_pkt_start(tx_pkt_start), .tx_pkt_end(tx_pkt_end), .tx_err(tx_err),
    .tx_force_burst(tx_force_burst), .tx_chan(tx_chan), .tx_data(tx_data),
    .tx_empty_cnt(tx_empty_cnt), .tx_ready(tx_ready),
    .tx_overflow(tx_overflow), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .out_valid(out_valid), .out_ctl(out_ctl), .out_word(out_word));
  ltbf_pkt_src u_ltbf_pkt_src (
    .core_clk(core_clk), .tx_ready(tx_ready), .tx_wr_valid(tx_wr_valid),
    .tx_pkt_start(tx_pkt_start), .tx_pkt_end(tx_pkt_end), .tx_err(tx_err),
    .tx_force_burst(tx_force_burst), .tx_chan(tx_chan), .tx_data(tx_data),
    .tx_empty_cnt(tx_empty_cnt));

  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // collect the framed stream
  always @(posedge core_clk) begin
    if (out_valid === 1'b1) got.push_back({out_ctl, out_word});
  end

  // ****************
  // compare and bus tasks
  // ****************
  task cmp_word(input logic [64:0] g, input logic [64:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("MISMATCH %0t word got %h exp %h", $time, g, e);
    end
  endtask
  task cmp_val(input logic [31:0] g, input logic [31:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("MISMATCH %0t value got %h exp %h", $time, g, e);
    end
  endtask
  task reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask

  // ****************
  // expected stream
  // ****************
  function logic [64:0] bcw(input logic sop, input logic [7:0] ch);
    bcw = {1'b1, 1'b1, sop, 4'h0, 1'b0, 9'h0, ch, 40'h0};
  endfunction
  function logic [64:0] icw(input logic [3:0] code, input logic er);
    icw = {1'b1, 1'b0, 1'b0, code, er, 57'h0};
  endfunction
  task build(input logic [7:0] ch, input logic [7:0] tag, input integer nw,
      input logic [3:0] mty, input logic er, input integer fw,
      input integer mx, input integer sh);
    integer w, l, nd, v, cnt, k, j;
    logic [64:0] d;
    begin
      cnt = -1;
      for (w = 0; w < nw; w = w + 1) begin
        v = (w == nw - 1) ? 16 - (er ? (mty & 4'h8) : mty) : 16;
        nd = (v + 7) / 8;
        for (l = 0; l < nd; l = l + 1) begin
          if (cnt < 0 || cnt == mx || (l == 0 && w == fw)) begin
            for (k = cnt; k >= 0 && k < sh; k = k + 1)
              exp.push_back(icw(4'h0, 1'b0));
            exp.push_back(bcw(cnt < 0, ch));
            cnt = 0;
          end
          d = 65'h0;
          for (j = 0; j < 8; j = j + 1)
            d[63-8*j -: 8] = tag + 8'(w*16+l*8+j);
          exp.push_back(d);
          cnt = cnt + 1;
        end
      end
      exp.push_back(icw({1'b1, 3'(v - 8 * nd + 7)}, er));
      for (k = cnt + 1; k < sh; k = k + 1)
        exp.push_back(icw(4'h0, 1'b0));
    end
  endtask
  // send one packet and check the whole framed stream
  task run_pkt(input logic [7:0] ch, input logic [7:0] tag, input integer nb,
      input logic er, input integer fw, input integer mx, input integer sh);
    integer nw, n;
    logic [3:0] mty;
    begin
      nw = (nb + 15) / 16;
      mty = 4'(nw * 16 - nb);
      got.delete();
      exp.delete();
      build(ch, tag, nw, mty, er, fw, mx, sh);
      u_ltbf_pkt_src.send(ch, tag, nw, mty, er, fw, 1'b0);
      n = 0;
      while (got.size() < exp.size() && n < 600) begin
        @(posedge core_clk);
        n = n + 1;
      end
      repeat (12) @(posedge core_clk);
      cmp_val(32'(got.size()), 32'(exp.size()));
      for (n = 0; n < exp.size() && n < got.size(); n = n + 1)
        cmp_word(got[n], exp[n]);
    end
  endtask

  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (40000) @(posedge core_clk);
    miscompares = miscompares + 1;
    $display("MISMATCH %0t watchdog expired", $time);
    end_of_test;
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    seed = 7492;
    miscompares = 0;
    cmp_count = 0;
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
    reg_read(`LTBF_ADDR_CFG, r);
    cmp_val(r, 32'h0004_0420);
    reg_write(`LTBF_ADDR_STATUS, 32'hffff_ffff);
    reg_read(`LTBF_ADDR_STATUS, r);
    cmp_val(r & 32'h3, 32'h2);
    reg_read(8'h3c, r);
    cmp_val(r, 32'h0);
    $display("test registers done");
    run_pkt(8'h05, 8'h10, 8, 1'b0, 99, 32, 4);
    run_pkt(8'h06, 8'h20, 264, 1'b0, 99, 32, 4);
    run_pkt(8'h07, 8'h30, 264, 1'b0, 8, 32, 4);
    run_pkt(8'h08, 8'h40, 11, 1'b1, 99, 32, 4);
    $display("test corners done");
    reg_write(`LTBF_ADDR_CFG, 32'h0004_0304);
    for (i = 0; i < 12; i = i + 1)
      run_pkt(8'($random(seed)), 8'($random(seed)), 1 + {$random(seed)} % 80,
              1'($random(seed)), {$random(seed)} % 8, 4, 3);
    $display("test random done");
    u_ltbf_pkt_src.send(8'h09, 8'h50, 24, 4'h0, 1'b0, 99, 1'b1);
    @(negedge core_clk);
    cmp_val({31'h0, tx_overflow}, 32'h1);
    repeat (30) @(negedge core_clk);
    reg_read(`LTBF_ADDR_STATUS, r);
    cmp_val(r & 32'h1, 32'h1);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
    reg_read(`LTBF_ADDR_STATUS, r);
    cmp_val(r & 32'h3, 32'h2);
    run_pkt(8'h0a, 8'h60, 40, 1'b0, 99, 32, 4);
    $display("test overflow done");
    end_of_test;
  end
endmodule
